// *** rtl/vfc_pkg.sv ***
package vfc_pkg;
   // Register byte offsets (printed offsets are not all multiples of four: index*4 on APB)
   localparam logic [13:0] IDX_RX_WRITE_INDEX = 14'h2764;
   localparam logic [13:0] IDX_RX_STATUS = 14'h276a;
   localparam logic [13:0] IDX_RX_DMA_LENGTH = 14'h276b;
   localparam logic [13:0] IDX_TX_IRQ_ENABLE = 14'h2770;
   localparam logic [13:0] IDX_RX_IRQ_ENABLE = 14'h2771;
   localparam logic [13:0] IDX_DMA_IRQ_ENABLE = 14'h2772;
   localparam logic [13:0] IDX_TX_IRQ_SOURCE = 14'h2773;
   localparam logic [13:0] IDX_RX_IRQ_SOURCE = 14'h2774;
   localparam logic [13:0] IDX_DMA_IRQ_SOURCE = 14'h2775;
   localparam logic [13:0] IDX_INTERFACE_SELECT = 14'h277a;
   localparam logic [13:0] IDX_PATH_CONTROL = 14'h277e;
   // Locally placed registers
   localparam logic [13:0] IDX_RX_READ_INDEX = 14'h2763;
   localparam logic [13:0] IDX_RX_BUFFER_CONTROL = 14'h2762;
   localparam logic [13:0] IDX_RX_MUTE_BYTE = 14'h2761;
   localparam logic [13:0] IDX_PATH_MUTE_HIGH = 14'h277c;
   localparam logic [13:0] IDX_PATH_MUTE_LOW = 14'h277d;
   // Field positions
   localparam int BIT_EMPTY = 7;
   localparam int BIT_FULL = 6;
   localparam int BIT_TX_DONE = 4;
   localparam int BIT_RX_DONE = 0;
   localparam int BIT_FILLING = 4;
   localparam int BIT_PUSH = 3;
   localparam int BIT_POP = 2;
   localparam int BIT_DEC_MUTE = 6;
   localparam int BIT_DEC_REINIT = 5;
   localparam int BIT_DEC_SPLIT = 4;
   localparam int BIT_ENC_MUTE = 2;
   localparam int BIT_ENC_REINIT = 1;
   localparam int BIT_ENC_PACK = 0;
   localparam int BIT_CLEAR = 1;
   localparam int BIT_FILL = 0;
   localparam int SEL_LSB = 5;
   // Buffer geometry and reset values
   localparam int DEPTH = 128;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] MASK_TX_EN = 8'hc0;
   localparam logic [7:0] MASK_DMA = 8'h11;
   localparam logic [7:0] MASK_SEL = 8'h60;
   localparam logic [7:0] MASK_PATH = 8'h55;
   // Interface selector codes
   typedef enum logic [1:0] {VFC_I2S, VFC_SPI, VFC_FIRST_UART, VFC_SECOND_UART} vfc_sel_t;
endpackage : vfc_pkg

// *** rtl/vfc_voice_ctrl.sv ***
`timescale 1ns/1ps
module vfc_voice_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive buffer push (from receive DMA) and pop (to decoder side)
   input wire logic rx_push_valid,
   input wire logic [7:0] rx_push_data,
   output logic rx_push_ready,
   input wire logic rx_pop_req,
   output logic rx_pop_valid,
   output logic [7:0] rx_pop_data,
   // Event inputs from transmit buffer and DMA engines
   input wire logic tx_empty_cond,
   input wire logic tx_full_cond,
   input wire logic tx_dma_complete,
   input wire logic rx_dma_complete,
   output logic [7:0] rx_voice_dma_length,
   output logic [1:0] interface_selector,
   // Decoder to external: 16-bit words split into bytes
   input wire logic dec_word_valid,
   input wire logic [15:0] dec_word,
   output logic dec_word_ready,
   output logic ext_tx_valid,
   output logic [7:0] ext_tx_byte,
   input wire logic ext_tx_ready,
   // External to encoder: bytes packed into words
   input wire logic ext_rx_valid,
   input wire logic [7:0] ext_rx_byte,
   output logic enc_word_valid,
   output logic [15:0] enc_word
);
   // Byte index from a word-aligned APB address
   function automatic logic [13:0] byte_index(input logic [15:0] a);
      return a[15:2];
   endfunction : byte_index

   // Storage and pointers
   logic [7:0] mem [vfc_pkg::DEPTH];
   logic [7:0] wr_idx_q; // Write index, bit 7 is the wrap bit
   logic [7:0] rd_idx_q;
   logic [7:0] mute_byte_q;
   logic filling_q; // Mute fill in progress
   logic [6:0] fill_addr_q;
   logic overflow_q;
   logic underflow_q;
   logic [7:0] dma_len_q;
   logic [7:0] tx_en_q, rx_en_q, dma_en_q;
   logic [7:0] tx_src_q, rx_src_q, dma_src_q;
   logic [7:0] sel_q;
   logic [7:0] path_q;
   logic [7:0] mute_hi_q, mute_lo_q;
   logic buf_empty, buf_full;
   logic wr_en, rd_en;
   logic [13:0] idx;
   logic do_push, do_pop;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign idx = byte_index(paddr);
   assign pready = 1'b1; // Zero wait states
   assign pslverr = 1'b0;

   // Pointer compare
   assign buf_empty = (wr_idx_q == rd_idx_q);
   assign buf_full = (wr_idx_q[6:0] == rd_idx_q[6:0]) && (wr_idx_q[7] != rd_idx_q[7]);
   // Pushes and pops stall while filling; that keeps fill writes from racing data
   assign rx_push_ready = ~buf_full & ~filling_q;
   assign do_push = rx_push_valid & rx_push_ready;
   assign do_pop = rx_pop_req & ~buf_empty & ~filling_q;

   // Control writes that act as commands
   logic clr_cmd, fill_cmd;
   assign clr_cmd = wr_en && idx == vfc_pkg::IDX_RX_BUFFER_CONTROL && pwdata[vfc_pkg::BIT_CLEAR];
   assign fill_cmd = wr_en && idx == vfc_pkg::IDX_RX_BUFFER_CONTROL && pwdata[vfc_pkg::BIT_FILL];

   // Write index
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_idx_q <= vfc_pkg::RST_BYTE;
      end else if (clr_cmd) begin
         wr_idx_q <= vfc_pkg::RST_BYTE;
      end else if (wr_en && idx == vfc_pkg::IDX_RX_WRITE_INDEX) begin
         wr_idx_q <= pwdata[7:0];
      end else if (do_push) begin
         wr_idx_q <= wr_idx_q + 8'h01;
      end
   end

   // Read index
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_idx_q <= vfc_pkg::RST_BYTE;
      end else if (clr_cmd) begin
         rd_idx_q <= vfc_pkg::RST_BYTE;
      end else if (wr_en && idx == vfc_pkg::IDX_RX_READ_INDEX) begin
         rd_idx_q <= pwdata[7:0];
      end else if (do_pop) begin
         rd_idx_q <= rd_idx_q + 8'h01;
      end
   end

   // Overflow and underflow record; clear wins only when no new error
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overflow_q <= 1'b0;
         underflow_q <= 1'b0;
      end else begin
         overflow_q <= (overflow_q & ~clr_cmd) | (rx_push_valid & buf_full);
         underflow_q <= (underflow_q & ~clr_cmd) | (rx_pop_req & buf_empty);
      end
   end

   // Mute fill sequencer, one entry per clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         filling_q <= 1'b0;
         fill_addr_q <= 7'h00;
      end else if (fill_cmd && !filling_q) begin
         filling_q <= 1'b1;
         fill_addr_q <= 7'h00;
      end else if (filling_q) begin
         fill_addr_q <= fill_addr_q + 7'h01;
         if (fill_addr_q == 7'h7f) begin
            filling_q <= 1'b0;
         end
      end
   end

   // Storage array, no reset
   always_ff @(posedge ref_clk) begin
      if (filling_q) begin
         mem[fill_addr_q] <= mute_byte_q;
      end else if (do_push) begin
         mem[wr_idx_q[6:0]] <= rx_push_data;
      end
   end

   // Pop data and push/pop activity flags
   logic push_active_q, pop_active_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_pop_valid <= 1'b0;
         rx_pop_data <= vfc_pkg::RST_BYTE;
         push_active_q <= 1'b0;
         pop_active_q <= 1'b0;
      end else begin
         rx_pop_valid <= do_pop;
         push_active_q <= do_push;
         pop_active_q <= do_pop;
         if (do_pop) begin
            rx_pop_data <= mem[rd_idx_q[6:0]];
         end
      end
   end

   // Plain configuration registers; unused bits are masked (software writes zero)
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dma_len_q <= vfc_pkg::RST_BYTE;
         tx_en_q <= vfc_pkg::RST_BYTE;
         rx_en_q <= vfc_pkg::RST_BYTE;
         dma_en_q <= vfc_pkg::RST_BYTE;
         sel_q <= vfc_pkg::RST_BYTE;
         mute_byte_q <= vfc_pkg::RST_BYTE;
         mute_hi_q <= vfc_pkg::RST_BYTE;
         mute_lo_q <= vfc_pkg::RST_BYTE;
      end else if (wr_en) begin
         unique case (idx)
            vfc_pkg::IDX_RX_DMA_LENGTH: dma_len_q <= pwdata[7:0];
            vfc_pkg::IDX_TX_IRQ_ENABLE: tx_en_q <= pwdata[7:0] & vfc_pkg::MASK_TX_EN;
            vfc_pkg::IDX_RX_IRQ_ENABLE: rx_en_q <= pwdata[7:0] & vfc_pkg::MASK_TX_EN;
            vfc_pkg::IDX_DMA_IRQ_ENABLE: dma_en_q <= pwdata[7:0] & vfc_pkg::MASK_DMA;
            vfc_pkg::IDX_INTERFACE_SELECT: sel_q <= pwdata[7:0] & vfc_pkg::MASK_SEL;
            vfc_pkg::IDX_RX_MUTE_BYTE: mute_byte_q <= pwdata[7:0];
            vfc_pkg::IDX_PATH_MUTE_HIGH: mute_hi_q <= pwdata[7:0];
            vfc_pkg::IDX_PATH_MUTE_LOW: mute_lo_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Path control; reinit bits are one-shot and self-clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         path_q <= vfc_pkg::RST_BYTE;
      end else if (wr_en && idx == vfc_pkg::IDX_PATH_CONTROL) begin
         path_q <= pwdata[7:0] & 8'h7f;
      end else begin
         path_q[vfc_pkg::BIT_DEC_REINIT] <= 1'b0;
         path_q[vfc_pkg::BIT_ENC_REINIT] <= 1'b0;
      end
   end

   // Sticky sources: set wins over a software write of zero
   logic [7:0] tx_set, rx_set, dma_set;
   assign tx_set = {tx_en_q[vfc_pkg::BIT_EMPTY] & tx_empty_cond,
                    tx_en_q[vfc_pkg::BIT_FULL] & tx_full_cond, 6'h00};
   assign rx_set = {rx_en_q[vfc_pkg::BIT_EMPTY] & buf_empty,
                    rx_en_q[vfc_pkg::BIT_FULL] & buf_full, 6'h00};
   assign dma_set = {3'h0, dma_en_q[vfc_pkg::BIT_TX_DONE] & tx_dma_complete, 3'h0,
                     dma_en_q[vfc_pkg::BIT_RX_DONE] & rx_dma_complete};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_src_q <= vfc_pkg::RST_BYTE;
         rx_src_q <= vfc_pkg::RST_BYTE;
         dma_src_q <= vfc_pkg::RST_BYTE;
      end else begin
         tx_src_q <= ((wr_en && idx == vfc_pkg::IDX_TX_IRQ_SOURCE) ?
                      pwdata[7:0] & vfc_pkg::MASK_TX_EN : tx_src_q) | tx_set;
         rx_src_q <= ((wr_en && idx == vfc_pkg::IDX_RX_IRQ_SOURCE) ?
                      pwdata[7:0] & vfc_pkg::MASK_TX_EN : rx_src_q) | rx_set;
         dma_src_q <= ((wr_en && idx == vfc_pkg::IDX_DMA_IRQ_SOURCE) ?
                       pwdata[7:0] & vfc_pkg::MASK_DMA : dma_src_q) | dma_set;
      end
   end

   // Decoder splitter: high byte first, then low
   logic dec_half_q; // 1 while low byte pending
   logic [7:0] dec_low_q;
   logic dec_split, dec_mute;
   assign dec_split = path_q[vfc_pkg::BIT_DEC_SPLIT];
   assign dec_mute = path_q[vfc_pkg::BIT_DEC_MUTE] & dec_split;
   assign dec_word_ready = ~dec_half_q & (~ext_tx_valid | ext_tx_ready);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dec_half_q <= 1'b0;
         dec_low_q <= vfc_pkg::RST_BYTE;
         ext_tx_valid <= 1'b0;
         ext_tx_byte <= vfc_pkg::RST_BYTE;
      end else if (path_q[vfc_pkg::BIT_DEC_REINIT]) begin
         dec_half_q <= 1'b0;
         ext_tx_valid <= 1'b0;
      end else if (~ext_tx_valid | ext_tx_ready) begin
         if (dec_half_q) begin
            ext_tx_valid <= 1'b1;
            ext_tx_byte <= dec_low_q;
            dec_half_q <= 1'b0;
         end else if (dec_word_valid) begin
            ext_tx_valid <= 1'b1;
            if (dec_split) begin
               ext_tx_byte <= dec_mute ? mute_hi_q : dec_word[15:8];
               dec_low_q <= dec_mute ? mute_lo_q : dec_word[7:0];
               dec_half_q <= 1'b1;
            end else begin
               ext_tx_byte <= dec_word[7:0];
            end
         end else begin
            ext_tx_valid <= 1'b0;
         end
      end
   end

   // Encoder packer: first byte forms high half
   logic enc_half_q;
   logic enc_pack, enc_mute;
   logic [7:0] enc_in;
   assign enc_pack = path_q[vfc_pkg::BIT_ENC_PACK];
   assign enc_mute = path_q[vfc_pkg::BIT_ENC_MUTE] & enc_pack;
   assign enc_in = enc_mute ? (enc_half_q ? mute_lo_q : mute_hi_q) : ext_rx_byte;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enc_half_q <= 1'b0;
         enc_word_valid <= 1'b0;
         enc_word <= 16'h0000;
      end else if (path_q[vfc_pkg::BIT_ENC_REINIT]) begin
         enc_half_q <= 1'b0;
         enc_word_valid <= 1'b0;
      end else begin
         enc_word_valid <= 1'b0;
         if (ext_rx_valid) begin
            if (!enc_pack) begin
               enc_word <= {8'h00, ext_rx_byte};
               enc_word_valid <= 1'b1;
            end else if (!enc_half_q) begin
               enc_word[15:8] <= enc_in;
               enc_half_q <= 1'b1;
            end else begin
               enc_word[7:0] <= enc_in;
               enc_half_q <= 1'b0;
               enc_word_valid <= 1'b1;
            end
         end
      end
   end

   assign rx_voice_dma_length = dma_len_q;
   assign interface_selector = sel_q[6:5];

   // Read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         unique case (idx)
            vfc_pkg::IDX_RX_WRITE_INDEX: prdata[7:0] = wr_idx_q;
            vfc_pkg::IDX_RX_READ_INDEX: prdata[7:0] = rd_idx_q;
            vfc_pkg::IDX_RX_STATUS: prdata[7:0] = {3'h0, filling_q, push_active_q,
                                                   pop_active_q, 2'h0};
            vfc_pkg::IDX_RX_DMA_LENGTH: prdata[7:0] = dma_len_q;
            vfc_pkg::IDX_TX_IRQ_ENABLE: prdata[7:0] = tx_en_q;
            vfc_pkg::IDX_RX_IRQ_ENABLE: prdata[7:0] = rx_en_q;
            vfc_pkg::IDX_DMA_IRQ_ENABLE: prdata[7:0] = dma_en_q;
            vfc_pkg::IDX_TX_IRQ_SOURCE: prdata[7:0] = tx_src_q;
            vfc_pkg::IDX_RX_IRQ_SOURCE: prdata[7:0] = rx_src_q;
            vfc_pkg::IDX_DMA_IRQ_SOURCE: prdata[7:0] = dma_src_q;
            vfc_pkg::IDX_INTERFACE_SELECT: prdata[7:0] = sel_q;
            vfc_pkg::IDX_PATH_CONTROL: prdata[7:0] = path_q;
            vfc_pkg::IDX_RX_MUTE_BYTE: prdata[7:0] = mute_byte_q;
            vfc_pkg::IDX_PATH_MUTE_HIGH: prdata[7:0] = mute_hi_q;
            vfc_pkg::IDX_PATH_MUTE_LOW: prdata[7:0] = mute_lo_q;
            vfc_pkg::IDX_RX_BUFFER_CONTROL: prdata[7:0] = {6'h00, overflow_q, underflow_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule : vfc_voice_ctrl

// *** test/vfc_voice_ctrl_assertions.sv ***
`timescale 1ns/1ps
// Port-level checks on the voice control block
module vfc_voice_ctrl_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic rx_push_ready,
   input wire logic rx_pop_req,
   input wire logic rx_pop_valid,
   input wire logic ext_rx_valid,
   input wire logic enc_word_valid,
   input wire logic ext_tx_valid,
   input wire logic [7:0] ext_tx_byte,
   input wire logic ext_tx_ready,
   input wire logic [7:0] rx_voice_dma_length,
   input wire logic [1:0] interface_selector
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic wr; // Completed APB write
   logic len_wr; // Write to the DMA length register
   logic sel_wr; // Write to the interface selector register
   assign wr = psel && penable && pwrite;
   assign len_wr = wr && paddr == {vfc_pkg::IDX_RX_DMA_LENGTH, 2'h0};
   assign sel_wr = wr && paddr == {vfc_pkg::IDX_INTERFACE_SELECT, 2'h0};
   logic dec_reinit_wr; // Write that restarts the word splitter
   assign dec_reinit_wr = wr && paddr == {vfc_pkg::IDX_PATH_CONTROL, 2'h0} &&
                          pwdata[vfc_pkg::BIT_DEC_REINIT];
   // Fill request written to the buffer control register
   sequence fill_wr;
      wr && paddr == {vfc_pkg::IDX_RX_BUFFER_CONTROL, 2'h0} && pwdata[vfc_pkg::BIT_FILL];
   endsequence
   // Pushes stay blocked for the first 8 cycles of the mute fill
   sequence push_held;
      !rx_push_ready [*8];
   endsequence
   a_len_write: assert property (len_wr |=> rx_voice_dma_length == $past(pwdata[7:0]))
      else $error("length not loaded");
   a_len_hold: assert property (!len_wr |=> $stable(rx_voice_dma_length))
      else $error("length changed unasked");
   a_sel_write: assert property (sel_wr |=> interface_selector == $past(pwdata[6:5]))
      else $error("selector not loaded");
   a_sel_hold: assert property (!sel_wr |=> $stable(interface_selector))
      else $error("selector changed unasked");
   a_fill_blocks: assert property (fill_wr |=> push_held)
      else $error("push open during fill");
   a_pop_cause: assert property (rx_pop_valid |-> $past(rx_pop_req))
      else $error("pop data without request");
   // A splitter restart may drop a stalled byte, so the cycle after one is exempt
   a_tx_byte_hold: assert property (ext_tx_valid && !ext_tx_ready && !$past(dec_reinit_wr) |=>
      ext_tx_valid && $stable(ext_tx_byte))
      else $error("byte dropped while stalled");
   a_dec_reinit: assert property (dec_reinit_wr |=> ##1 !ext_tx_valid)
      else $error("splitter not restarted");
   a_enc_cause: assert property (enc_word_valid |-> $past(ext_rx_valid))
      else $error("word without byte");
endmodule : vfc_voice_ctrl_checker

bind vfc_voice_ctrl vfc_voice_ctrl_checker chk_i (.ref_clk, .rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .rx_push_ready, .rx_pop_req, .rx_pop_valid, .ext_rx_valid,
   .enc_word_valid, .ext_tx_valid, .ext_tx_byte, .ext_tx_ready, .rx_voice_dma_length,
   .interface_selector);

// *** test/vfc_ext_model.sv ***
`timescale 1ns/1ps
// External byte sink; it stalls every other cycle when slow is set, always when hold is set
module vfc_ext_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic hold,
   input wire logic ext_tx_valid,
   input wire logic [7:0] ext_tx_byte,
   output logic ext_tx_ready
);
   logic [7:0] got[$]; // Bytes taken off the link, oldest first
   // Toggling ready forces the sender to hold its byte
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_tx_ready <= 1'h0;
      end else begin
         ext_tx_ready <= hold ? 1'h0 : (slow ? !ext_tx_ready : 1'h1);
      end
   end
   // Only a completed handshake delivers a byte
   always @(posedge ref_clk) begin
      if (!rst && ext_tx_valid === 1'h1 && ext_tx_ready === 1'h1) got.push_back(ext_tx_byte);
   end
endmodule : vfc_ext_model

// *** test/voice_fifo_interface_control_test.sv ***
`timescale 1ns/1ps
module voice_fifo_interface_control_test;
   logic ref_clk = 1'h0, rst = 1'h1, slow = 1'h0; // Clock, reset, sink pace
   logic hold = 1'h0; // Sink stall, keeps a byte pending
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [15:0] paddr = 16'h0, dec_word = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic rx_push_valid = 1'h0, rx_pop_req = 1'h0, tx_empty_cond = 1'h0, tx_full_cond = 1'h0;
   logic tx_dma_complete = 1'h0, rx_dma_complete = 1'h0, dec_word_valid = 1'h0;
   logic ext_rx_valid = 1'h0, ext_tx_ready;
   logic [7:0] rx_push_data = 8'h0, ext_rx_byte = 8'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rx_push_ready, rx_pop_valid, dec_word_ready, ext_tx_valid;
   logic enc_word_valid;
   logic [7:0] rx_pop_data, rx_voice_dma_length, ext_tx_byte;
   logic [1:0] interface_selector;
   logic [15:0] enc_word;
   logic [15:0] encq[$]; // Encoder words seen, oldest first
   logic [7:0] tx_exp[4] = '{8'h12, 8'h34, 8'hab, 8'hcd}; // Split order, high byte first
   int err_total = 0;
   int tests_run = 0;
   vfc_voice_ctrl uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rx_push_valid, .rx_push_data, .rx_push_ready, .rx_pop_req,
      .rx_pop_valid, .rx_pop_data, .tx_empty_cond, .tx_full_cond, .tx_dma_complete,
      .rx_dma_complete, .rx_voice_dma_length, .interface_selector, .dec_word_valid, .dec_word,
      .dec_word_ready, .ext_tx_valid, .ext_tx_byte, .ext_tx_ready, .ext_rx_valid,
      .ext_rx_byte, .enc_word_valid, .enc_word);
   vfc_ext_model ext (.ref_clk, .rst, .slow, .hold, .ext_tx_valid, .ext_tx_byte, .ext_tx_ready);
   always #2.5 ref_clk = ~ref_clk;
   // Collect every encoder word pulse
   always @(posedge ref_clk) if (enc_word_valid === 1'h1) encq.push_back(enc_word);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; holds the request until pready is seen
   task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'h1;
      do @(posedge ref_clk); while (pready !== 1'h1);
      q = prdata[7:0];
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      logic [7:0] q;
      apb(1'h1, idx, d, q);
   endtask : wr
   task automatic rd(input logic [13:0] idx, input logic [7:0] e);
      logic [7:0] q;
      apb(1'h0, idx, 8'h0, q);
      chk({8'h0, q}, {8'h0, e});
   endtask : rd
   task automatic push(input logic [7:0] b);
      @(posedge ref_clk);
      rx_push_valid <= 1'h1;
      rx_push_data <= b;
      do @(posedge ref_clk); while (rx_push_ready !== 1'h1);
      rx_push_valid <= 1'h0;
   endtask : push
   task automatic pop(input logic [7:0] e);
      @(posedge ref_clk);
      rx_pop_req <= 1'h1;
      @(posedge ref_clk);
      rx_pop_req <= 1'h0;
      #1 chk({7'h0, rx_pop_valid, rx_pop_data}, {8'h1, e});
   endtask : pop
   task automatic dec(input logic [15:0] w);
      @(posedge ref_clk);
      dec_word_valid <= 1'h1;
      dec_word <= w;
      do @(posedge ref_clk); while (dec_word_ready !== 1'h1);
      dec_word_valid <= 1'h0;
   endtask : dec
   task automatic eb(input logic [7:0] b);
      @(posedge ref_clk);
      ext_rx_valid <= 1'h1;
      ext_rx_byte <= b;
      @(posedge ref_clk);
      ext_rx_valid <= 1'h0;
   endtask : eb
   // Bounded waits for the next byte or word at the far side
   task automatic take(input logic enc, input logic [15:0] e);
      int n;
      n = 0;
      while ((enc ? encq.size() : ext.got.size()) == 0 && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      if (enc) chk(encq.size() ? encq.pop_front() : 16'hxxxx, e);
      else chk({8'h0, ext.got.size() ? ext.got.pop_front() : 8'hxx}, e);
   endtask : take
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   // Watchdog of 20000 cycles, well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      test_done();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      // Reset values of the write index, status, length, three enable and DMA source registers
      rd(vfc_pkg::IDX_RX_WRITE_INDEX, 8'h0);
      rd(vfc_pkg::IDX_RX_STATUS, 8'h0);
      rd(vfc_pkg::IDX_RX_DMA_LENGTH, 8'h0);
      rd(vfc_pkg::IDX_TX_IRQ_ENABLE, 8'h0);
      rd(vfc_pkg::IDX_RX_IRQ_ENABLE, 8'h0);
      rd(vfc_pkg::IDX_DMA_IRQ_ENABLE, 8'h0);
      rd(vfc_pkg::IDX_DMA_IRQ_SOURCE, 8'h0);
      chk({15'h0, pslverr}, 16'h0);
      $display("reset test done");
      // Read/write fields, unused bits masked
      wr(vfc_pkg::IDX_RX_DMA_LENGTH, 8'ha5);
      rd(vfc_pkg::IDX_RX_DMA_LENGTH, 8'ha5);
      for (int k = 0; k < 4; k++) begin
         wr(vfc_pkg::IDX_INTERFACE_SELECT, {1'h0, 2'(k), 5'h0});
         #1 chk({14'h0, interface_selector}, 16'(k));
      end
      wr(vfc_pkg::IDX_TX_IRQ_ENABLE, 8'hff);
      rd(vfc_pkg::IDX_TX_IRQ_ENABLE, 8'hc0);
      wr(vfc_pkg::IDX_DMA_IRQ_ENABLE, 8'hff);
      rd(vfc_pkg::IDX_DMA_IRQ_ENABLE, 8'h11);
      wr(vfc_pkg::IDX_RX_IRQ_ENABLE, 8'h7f);
      rd(vfc_pkg::IDX_RX_IRQ_ENABLE, 8'h40);
      $display("register test done");
      // Sticky sources set by events, cleared by software
      @(posedge ref_clk);
      {tx_empty_cond, tx_full_cond, tx_dma_complete, rx_dma_complete} <= 4'hf;
      @(posedge ref_clk);
      {tx_empty_cond, tx_full_cond, tx_dma_complete, rx_dma_complete} <= 4'h0;
      rd(vfc_pkg::IDX_TX_IRQ_SOURCE, 8'hc0);
      rd(vfc_pkg::IDX_DMA_IRQ_SOURCE, 8'h11);
      wr(vfc_pkg::IDX_TX_IRQ_SOURCE, 8'h0);
      rd(vfc_pkg::IDX_TX_IRQ_SOURCE, 8'h0);
      $display("source test done");
      // Push and pop flags, then fill to the wrap point
      fork push(8'h3c); rd(vfc_pkg::IDX_RX_STATUS, 8'h08); join
      fork pop(8'h3c); rd(vfc_pkg::IDX_RX_STATUS, 8'h04); join
      for (int i = 0; i < 128; i++) push(8'(i));
      #1 chk({15'h0, rx_push_ready}, 16'h0);
      rd(vfc_pkg::IDX_RX_WRITE_INDEX, 8'h81);
      rd(vfc_pkg::IDX_RX_IRQ_SOURCE, 8'h40);
      wr(vfc_pkg::IDX_RX_BUFFER_CONTROL, 8'h02);
      rd(vfc_pkg::IDX_RX_WRITE_INDEX, 8'h0);
      rd(vfc_pkg::IDX_RX_READ_INDEX, 8'h0);
      // Mute fill, then expose two filled entries
      wr(vfc_pkg::IDX_RX_MUTE_BYTE, 8'h5a);
      wr(vfc_pkg::IDX_RX_BUFFER_CONTROL, 8'h01);
      rd(vfc_pkg::IDX_RX_STATUS, 8'h10);
      repeat (130) @(posedge ref_clk);
      rd(vfc_pkg::IDX_RX_STATUS, 8'h0);
      wr(vfc_pkg::IDX_RX_WRITE_INDEX, 8'h02);
      pop(8'h5a);
      pop(8'h5a);
      $display("buffer test done");
      // Word splitting, prompt then stalled sink, then mute
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h10);
      dec(16'h1234);
      slow <= 1'h1;
      dec(16'habcd);
      foreach (tx_exp[i]) take(1'h0, {8'h0, tx_exp[i]});
      wr(vfc_pkg::IDX_PATH_MUTE_HIGH, 8'haa);
      wr(vfc_pkg::IDX_PATH_MUTE_LOW, 8'h55);
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h50);
      dec(16'h1234);
      take(1'h0, 16'haa);
      take(1'h0, 16'h55);
      // Restart with a byte stalled at the sink: the pending word is dropped
      hold <= 1'h1;
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h10);
      dec(16'h5678);
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h30);
      hold <= 1'h0;
      dec(16'h9abc);
      take(1'h0, 16'h9a);
      take(1'h0, 16'hbc);
      // Splitting off passes the low byte alone
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h00);
      dec(16'h9876);
      take(1'h0, 16'h76);
      $display("decoder test done");
      // Byte packing, packer reinit mid-word, mute
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h01);
      eb(8'hab);
      eb(8'hcd);
      take(1'h1, 16'habcd);
      eb(8'h11);
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h03);
      eb(8'h22);
      eb(8'h33);
      take(1'h1, 16'h2233);
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h05);
      eb(8'h01);
      eb(8'h02);
      take(1'h1, 16'haa55);
      // Packing off hands each byte over alone
      wr(vfc_pkg::IDX_PATH_CONTROL, 8'h00);
      eb(8'h44);
      take(1'h1, 16'h0044);
      $display("encoder test done");
      test_done();
   end
endmodule : voice_fifo_interface_control_test
